// *** shared/spi_fault_defines.vh ***
`ifndef SPI_FAULT_DEFINES_VH
`define SPI_FAULT_DEFINES_VH

// ----------
// clock and timing
// ----------
`define CLK_MHZ 125
`define SHORT_DLY_US 21
`define LONG_DLY_US 40
`define REARM_DLY_US 24
`define SHORT_DLY_CYC (`SHORT_DLY_US * `CLK_MHZ)
`define LONG_DLY_CYC (`LONG_DLY_US * `CLK_MHZ)
`define REARM_DLY_CYC (`REARM_DLY_US * `CLK_MHZ)

// ----------
// frame format
// ----------
`define FRAME_BITS 16
`define FRAME_MSB 15
`define BIT_MOD_W 3
`define BIT_MOD_ZERO 3'h0

// ----------
// diagnosis codes, reset values and delay counter width
// ----------
`define DIAG_NONE 2'h0
`define DIAG_OCT 2'h2
`define SHIFT_RST 16'h0000
`define DLY_CNT_W 13

`endif

// *** core/sync2.v ***
`timescale 1ns/1ps
// ----------
// two-stage synchroniser for pins from outside the mclk domain
// ----------
module sync2 #(
    parameter W = 1,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    input wire mclk,
    input wire sys_rst,
    input wire [W-1:0] din,
    output reg [W-1:0] dout
);
    reg [W-1:0] meta; // first stage, read only by dout

    // first stage feeds second stage only
    always @(posedge mclk) begin
        if (sys_rst) begin
            meta <= RST_VAL;
            dout <= RST_VAL;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule

// *** core/frame_buffer2.v ***
`timescale 1ns/1ps
// ----------
// two-entry buffer with valid/ready on both sides
// ----------
module frame_buffer2 #(
    parameter W = 16
) (
    input wire mclk,
    input wire sys_rst,
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0] slot0; // entry storage
    reg [W-1:0] slot1;
    reg wr_ptr; // next slot to fill
    reg rd_ptr; // next slot to drain
    reg [1:0] fill; // entries held
    wire do_wr;
    wire do_rd;

    assign in_ready = (fill != 2'h2); // honest full
    assign out_valid = (fill != 2'h0); // honest empty
    assign out_data = rd_ptr ? slot1 : slot0;
    assign do_wr = in_valid & in_ready;
    assign do_rd = out_valid & out_ready;

    // storage writes
    always @(posedge mclk) begin
        if (sys_rst) begin
            slot0 <= {W{1'b0}};
            slot1 <= {W{1'b0}};
        end else if (do_wr) begin
            if (wr_ptr) begin
                slot1 <= in_data;
            end else begin
                slot0 <= in_data;
            end
        end
    end

    // pointers and fill level
    always @(posedge mclk) begin
        if (sys_rst) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            fill <= 2'h0;
        end else begin
            if (do_wr) begin
                wr_ptr <= ~wr_ptr;
            end
            if (do_rd) begin
                rd_ptr <= ~rd_ptr;
            end
            if (do_wr & ~do_rd) begin
                fill <= fill + 2'h1;
            end else if (do_rd & ~do_wr) begin
                fill <= fill - 2'h1;
            end
        end
    end
endmodule

// *** core/spi_frame_and_fault_latch.v ***
`timescale 1ns/1ps
`include "spi_fault_defines.vh"
// Operation
// RQ1 - overload fault latches channel off until cleared
// RQ2 - event during diagnosis write stored afterwards
// RQ3 - reverse comparator works only when enabled
// RQ4 - reverse detect drives channel on until limit
// RQ5 - after trip wait zero, then rearm delay
// RQ6 - high threshold trips after short delay
// RQ7 - low threshold trips after long delay
// RQ8 - four-wire full-duplex slave, host is master
// RQ9 - chip select fall starts a new frame
// RQ10 - input bit captured on clock falling edge
// RQ11 - output bit shifted on clock rising edge
// RQ12 - frame evaluated at chip select rise
// RQ13 - only multiples of eight bits accepted
// RQ14 - input bits pass through to output
// RQ15 - standard frame is sixteen bits
// RQ16 - host keeps serial clock at most 5 MHz; the bench host model runs it at 6.25 MHz
// RQ17 - overload fault reported as code 10
// RQ18 - diagnosis clear releases the fault latch
// RQ19 - data output released while deselected
module spi_frame_and_fault_latch #(
    parameter N = 10,
    parameter SHORT_DLY_CYC = `SHORT_DLY_CYC,
    parameter LONG_DLY_CYC = `LONG_DLY_CYC,
    parameter REARM_DLY_CYC = `REARM_DLY_CYC
) (
    input wire mclk,
    input wire sys_rst,
    input wire sclk_pin,
    input wire cs_n_pin,
    input wire sdi_pin,
    output reg sdo,
    output wire sdo_oe,
    input wire [`FRAME_MSB:0] tx_word,
    output wire [`FRAME_MSB:0] rx_word,
    output wire rx_valid,
    input wire rx_ready,
    output reg frame_overrun,
    input wire [N-1:0] channel_cmd,
    input wire [N-1:0] over_high_pin,
    input wire [N-1:0] over_low_pin,
    input wire [N-1:0] over_temp_pin,
    input wire [N-1:0] rev_detect_pin,
    input wire [N-1:0] rev_over_pin,
    input wire [N-1:0] rev_zero_pin,
    input wire diag_busy,
    input wire [N-1:0] diagnosis_clear_command,
    input wire reverse_comparator_enable,
    output reg [N-1:0] gate_on,
    output wire [2*N-1:0] diag_code,
    output wire [N-1:0] fault_latched,
    output wire [N-1:0] rev_on
);

    // ----------
    // state codes of the reverse comparator
    // ----------
    localparam [1:0] REV_ARMED = 2'h0; // waiting for reverse current
    localparam [1:0] REV_ACTIVE = 2'h1; // holding channel on
    localparam [1:0] REV_WAIT = 2'h2; // tripped, waiting for zero
    localparam [1:0] REV_REARM = 2'h3; // counting rearm delay

    localparam [`DLY_CNT_W-1:0] SHORT_CNT = SHORT_DLY_CYC[`DLY_CNT_W-1:0];
    localparam [`DLY_CNT_W-1:0] LONG_CNT = LONG_DLY_CYC[`DLY_CNT_W-1:0];
    localparam [`DLY_CNT_W-1:0] REARM_CNT = REARM_DLY_CYC[`DLY_CNT_W-1:0];

    // ----------
    // pin synchronisers
    // ----------
    wire sclk_s; // synchronised serial clock
    wire cs_n_s; // synchronised chip select, low active
    wire sdi_s; // synchronised serial data in
    wire [N-1:0] hi_s; // high threshold comparator
    wire [N-1:0] lo_s; // low threshold comparator
    wire [N-1:0] ot_s; // over temperature flag
    wire [N-1:0] rd_s; // reverse current seen
    wire [N-1:0] ro_s; // reverse current beyond switch-off level
    wire [N-1:0] rz_s; // reverse current back to zero

    // serial pins; chip select resets high so no false frame start
    sync2 #(
        .W(3),
        .RST_VAL(3'h2)
    ) u_sync_link (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .din({sclk_pin, cs_n_pin, sdi_pin}),
        .dout({sclk_s, cs_n_s, sdi_s})
    );

    // analogue comparator outputs, all channels in one bank
    sync2 #(
        .W(6*N),
        .RST_VAL({(6*N){1'b0}})
    ) u_sync_ana (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .din({over_high_pin, over_low_pin, over_temp_pin,
              rev_detect_pin, rev_over_pin, rev_zero_pin}),
        .dout({hi_s, lo_s, ot_s, rd_s, ro_s, rz_s})
    );

    // ----------
    // edge detection on the synchronised link
    // ----------
    reg sclk_q; // last sampled serial clock
    reg cs_n_q; // last sampled chip select
    wire sclk_rise;
    wire sclk_fall;
    wire cs_fall;
    wire cs_rise;
    wire selected;

    // previous values for edge finding
    always @(posedge mclk) begin
        if (sys_rst) begin
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
        end else begin
            sclk_q <= sclk_s;
            cs_n_q <= cs_n_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_q;
    assign sclk_fall = ~sclk_s & sclk_q;
    assign cs_fall = ~cs_n_s & cs_n_q; // RQ9
    assign cs_rise = cs_n_s & ~cs_n_q; // RQ12
    assign selected = ~cs_n_s; // RQ8

    // output driven only while selected, shared line otherwise
    assign sdo_oe = selected; // RQ19

    // ----------
    // frame shifter
    // ----------
    // one register serves both directions: bits leave at the top and
    // arrive at the bottom, which is what makes daisy chaining work
    reg [`FRAME_MSB:0] shifter; // shared in/out shift register
    reg [`BIT_MOD_W-1:0] bit_mod; // modulo-8 bit counter
    reg any_bit; // at least one bit clocked this frame
    reg [`FRAME_MSB:0] word_hold; // frame waiting for the buffer
    reg push; // one-cycle frame accept strobe
    wire buf_ready; // buffer can take a word
    wire frame_ok;

    // a frame is good only on a whole number of bytes
    assign frame_ok = any_bit & (bit_mod == `BIT_MOD_ZERO); // RQ13

    // shift engine, clocked by edges found in mclk
    always @(posedge mclk) begin
        if (sys_rst) begin
            shifter <= `SHIFT_RST;
            bit_mod <= `BIT_MOD_ZERO;
            any_bit <= 1'b0;
            sdo <= 1'b0;
        end else if (cs_fall) begin
            // new frame: load reply, first bit visible at once
            shifter <= tx_word; // RQ9
            bit_mod <= `BIT_MOD_ZERO;
            any_bit <= 1'b0;
            sdo <= tx_word[`FRAME_MSB];
        end else if (selected & sclk_rise) begin
            // present the top bit on the rising edge
            sdo <= shifter[`FRAME_MSB]; // RQ11
        end else if (selected & sclk_fall) begin
            // sample on the falling edge; old top bit moves on
            shifter <= {shifter[`FRAME_MSB-1:0], sdi_s}; // RQ10 RQ14
            bit_mod <= bit_mod + 3'h1; // RQ13
            any_bit <= 1'b1;
        end
    end

    // ----------
    // frame evaluation at chip select release
    // ----------
    // the sixteen bits in the shifter form the word, eight of them reply bits for an 8-bit frame; longer daisy
    // frames keep only the tail, which is this device's own slot
    always @(posedge mclk) begin
        if (sys_rst) begin
            push <= 1'b0;
            word_hold <= `SHIFT_RST;
        end else begin
            push <= 1'b0;
            if (cs_rise & frame_ok) begin
                push <= 1'b1; // RQ12
                word_hold <= shifter; // RQ15
            end
        end
    end

    // a full buffer cannot stall the master, so flag the loss
    always @(posedge mclk) begin
        if (sys_rst) begin
            frame_overrun <= 1'b0;
        end else begin
            frame_overrun <= push & ~buf_ready;
        end
    end

    // ----------
    // received word buffer
    // ----------
    frame_buffer2 #(
        .W(`FRAME_BITS)
    ) u_rx_buf (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .in_valid(push),
        .in_ready(buf_ready),
        .in_data(word_hold),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data(rx_word)
    );

    // ----------
    // per-channel protection logic
    // ----------
    wire [N-1:0] next_gate; // per-channel gate decision
    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : chan
            reg latched; // fault latch, holds channel off
            reg pending; // event caught during diagnosis write
            reg [1:0] code; // diagnosis field
            reg [`DLY_CNT_W-1:0] ovl_cnt; // overload delay counter
            reg [1:0] rev_state; // reverse comparator state
            reg [`DLY_CNT_W-1:0] rev_cnt; // rearm delay counter
            wire driving; // output currently on
            wire ovl_trip; // overload delay elapsed
            wire trip; // any protection event
            wire clr; // diagnosis clear for this channel

            assign driving = gate_on[g];
            assign clr = diagnosis_clear_command[g];

            // high threshold uses the short delay, low alone the long one
            assign ovl_trip = driving &
                ((hi_s[g] & (ovl_cnt >= SHORT_CNT - 1'b1)) | // RQ6
                 (~hi_s[g] & lo_s[g] & (ovl_cnt >= LONG_CNT - 1'b1))); // RQ7
            // temperature trips without delay
            assign trip = ovl_trip | (driving & ot_s[g]);

            // overload counter runs only while on and above a threshold
            always @(posedge mclk) begin
                if (sys_rst) begin
                    ovl_cnt <= {`DLY_CNT_W{1'b0}};
                end else if (driving & (hi_s[g] | lo_s[g]) & ~ovl_trip) begin
                    ovl_cnt <= ovl_cnt + 1'b1; // RQ6 RQ7
                end else begin
                    ovl_cnt <= {`DLY_CNT_W{1'b0}};
                end
            end

            // fault latch: a new trip wins over a clear in the same cycle
            always @(posedge mclk) begin
                if (sys_rst) begin
                    latched <= 1'b0;
                end else if (trip) begin
                    latched <= 1'b1; // RQ1
                end else if (clr) begin
                    latched <= 1'b0; // RQ18
                end
            end

            // diagnosis store, deferred while a write is under way
            always @(posedge mclk) begin
                if (sys_rst) begin
                    pending <= 1'b0;
                    code <= `DIAG_NONE;
                end else if (diag_busy) begin
                    // hold the event until the write finishes
                    if (trip) begin
                        pending <= 1'b1; // RQ2
                    end
                end else if (trip | pending) begin
                    code <= `DIAG_OCT; // RQ2 RQ17
                    pending <= 1'b0;
                end else if (clr) begin
                    code <= `DIAG_NONE; // RQ18
                end
            end

            // reverse comparator sequence
            always @(posedge mclk) begin
                if (sys_rst) begin
                    rev_state <= REV_ARMED;
                    rev_cnt <= {`DLY_CNT_W{1'b0}};
                end else begin
                    case (rev_state)
                        REV_ARMED: begin
                            // only an enabled comparator reacts
                            if (reverse_comparator_enable & rd_s[g] & ~ro_s[g]) begin
                                rev_state <= REV_ACTIVE; // RQ3 RQ4
                            end
                        end
                        REV_ACTIVE: begin
                            if (~reverse_comparator_enable) begin
                                rev_state <= REV_ARMED; // RQ3
                            end else if (ro_s[g]) begin
                                rev_state <= REV_WAIT; // RQ4
                            end else if (~rd_s[g]) begin
                                rev_state <= REV_ARMED;
                            end
                        end
                        REV_WAIT: begin
                            // off until the reverse current is gone
                            if (rz_s[g]) begin
                                rev_state <= REV_REARM; // RQ5
                                rev_cnt <= {`DLY_CNT_W{1'b0}};
                            end
                        end
                        default: begin
                            // current back: restart the wait
                            if (~rz_s[g]) begin
                                rev_state <= REV_WAIT;
                            end else if (rev_cnt >= REARM_CNT - 1'b1) begin
                                rev_state <= REV_ARMED; // RQ5
                            end else begin
                                rev_cnt <= rev_cnt + 1'b1;
                            end
                        end
                    endcase
                end
            end

            assign rev_on[g] = (rev_state == REV_ACTIVE) & reverse_comparator_enable;
            assign fault_latched[g] = latched;
            assign diag_code[2*g+1:2*g] = code;

            // gate: latch overrides both command and reverse drive
            assign next_gate[g] = ~latched & ~trip & (channel_cmd[g] | rev_on[g]); // RQ1 RQ4
        end
    endgenerate

    // one register for all gates, so each bit has a single driver
    always @(posedge mclk) begin
        if (sys_rst) begin
            gate_on <= {N{1'b0}};
        end else begin
            gate_on <= next_gate;
        end
    end

endmodule

// *** tb/spi_fault_sva.sv ***
`timescale 1ns/1ps
// ----------
// passive checker on the top-level ports
// ----------
module spi_fault_sva #(
    parameter N = 10,
    parameter SHORT_DLY_CYC = 2625,
    parameter LONG_DLY_CYC = 5000,
    parameter REARM_DLY_CYC = 3000
) (
    input wire mclk,
    input wire sys_rst,
    input wire cs_n_pin,
    input wire sdo_oe,
    input wire [15:0] rx_word,
    input wire rx_valid,
    input wire rx_ready,
    input wire frame_overrun,
    input wire [N-1:0] over_high_pin,
    input wire [N-1:0] rev_over_pin,
    input wire diag_busy,
    input wire [N-1:0] diagnosis_clear_command,
    input wire reverse_comparator_enable,
    input wire [N-1:0] gate_on,
    input wire [2*N-1:0] diag_code,
    input wire [N-1:0] fault_latched,
    input wire [N-1:0] rev_on
);
    // ----------
    // helper counters, channel 0 only
    // ----------
    reg [15:0] hi_cnt; // cycles of high overload while driven
    reg [15:0] off_cnt; // cycles since a reverse trip, saturating
    // a trip resets the count; enable drops do not, they are not trips
    always @(posedge mclk) begin
        if (sys_rst) begin
            hi_cnt <= 16'h0000;
            off_cnt <= 16'hffff;
        end else begin
            hi_cnt <= (over_high_pin[0] && gate_on[0]) ? hi_cnt + 16'h0001 : 16'h0000;
            if ($fell(rev_on[0]) && rev_over_pin[0]) begin
                off_cnt <= 16'h0001;
            end else if (off_cnt != 16'hffff) begin
                off_cnt <= off_cnt + 16'h0001;
            end
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    // ----------
    // assertions
    // ----------
    a_sdo_released: assert property (cs_n_pin [*4] |-> !sdo_oe)
        else $error("data output driven while deselected");
    a_oe_in_frame: assert property (!cs_n_pin [*4] |-> sdo_oe)
        else $error("data output not driven in frame");
    a_latch_gate_off: assert property (1'b1 |-> (fault_latched & gate_on) == '0)
        else $error("channel driven while latched");
    a_latch_until_clear: assert property (
        fault_latched[0] && !diagnosis_clear_command[0] |=> fault_latched[0])
        else $error("latch released without clear");
    a_code_reported: assert property (
        fault_latched[0] && !diag_busy && !diagnosis_clear_command[0]
        |=> diag_code[1:0] == 2'h2)
        else $error("fault code missing");
    a_code_deferred: assert property (
        diag_busy && diag_code[1:0] == 2'h0 |=> diag_code[1:0] == 2'h0)
        else $error("code stored during write");
    a_rev_enable: assert property (!reverse_comparator_enable |-> rev_on == '0)
        else $error("reverse comparator active while disabled");
    a_rev_gate: assert property ((rev_on[0] && !fault_latched[0]) [*2] |-> gate_on[0])
        else $error("reverse detect did not drive channel");
    a_rearm_delay: assert property ($rose(rev_on[0]) |-> off_cnt >= REARM_DLY_CYC)
        else $error("reverse comparator rearmed early");
    a_short_trip: assert property (hi_cnt >= SHORT_DLY_CYC + 8 |-> !gate_on[0])
        else $error("high overload not tripped");
    a_rx_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_word))
        else $error("buffered word lost under stall");
    a_overrun_pulse: assert property (frame_overrun |=> !frame_overrun)
        else $error("overrun longer than one cycle");
    c_overrun: cover property (frame_overrun);
    c_latch: cover property ($rose(fault_latched[0]));
    c_rev: cover property ($rose(rev_on[0]));
endmodule

bind spi_frame_and_fault_latch spi_fault_sva #(.N(N), .SHORT_DLY_CYC(SHORT_DLY_CYC),
    .LONG_DLY_CYC(LONG_DLY_CYC), .REARM_DLY_CYC(REARM_DLY_CYC)) u_sva (
    .mclk, .sys_rst, .cs_n_pin, .sdo_oe, .rx_word, .rx_valid, .rx_ready,
    .frame_overrun, .over_high_pin, .rev_over_pin, .diag_busy,
    .diagnosis_clear_command, .reverse_comparator_enable, .gate_on, .diag_code,
    .fault_latched, .rev_on);

// *** tb/spi_host_model.sv ***
`timescale 1ns/1ps
// ----------
// host master on the serial port
// ----------
module spi_host_model (
    input wire mclk,
    input wire sdo_line,
    output reg sclk_pin,
    output reg cs_n_pin,
    output reg sdi_pin
);
    localparam int HALF = 10; // 80 ns half period, 160 ns per bit
    // clock idles low and stands still between frames
    initial begin
        sclk_pin = 1'b0;
        cs_n_pin = 1'b1;
        sdi_pin = 1'b0;
    end
    // full duplex burst, low nb bits of data msb first
    task automatic xfer(input int nb, input logic [31:0] data, output logic [31:0] got);
        int i;
        got = 32'h0;
        @(posedge mclk);
        cs_n_pin <= 1'b0;
        repeat (HALF) @(posedge mclk);
        for (i = nb - 1; i >= 0; i--) begin
            // sdi launched at the rise, sdo taken at the fall
            sclk_pin <= 1'b1;
            sdi_pin <= data[i];
            repeat (HALF) @(posedge mclk);
            got = {got[30:0], sdo_line};
            sclk_pin <= 1'b0;
            repeat (HALF) @(posedge mclk);
        end
        cs_n_pin <= 1'b1;
        sdi_pin <= ~sdi_pin; // no stale level outside frames
        repeat (HALF) @(posedge mclk);
    endtask
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ps
// ----------
// bench: host model plus queue scoreboard
// ----------
module testbench;
    localparam int NC = 10;
    localparam int SHORT = 20; // shortened overload delays
    localparam int LONG = 40;
    localparam int REARM = 25;
    reg mclk, sys_rst, rx_ready, diag_busy, reverse_comparator_enable, stall, last_sdo;
    reg [15:0] tx_word;
    reg [NC-1:0] channel_cmd, over_high_pin, over_low_pin, over_temp_pin;
    reg [NC-1:0] rev_detect_pin, rev_over_pin, rev_zero_pin, diagnosis_clear_command;
    wire sclk_pin, cs_n_pin, sdi_pin, sdo, sdo_oe, rx_valid, frame_overrun, sdo_line;
    wire [15:0] rx_word;
    wire [NC-1:0] gate_on, fault_latched, rev_on;
    wire [2*NC-1:0] diag_code;
    integer seed = 32'hdc0a;
    int error_cnt = 0, checked = 0, ovr_cnt = 0, cyc = 0;
    int nbs[6] = '{16, 16, 8, 12, 24, 32}; // 12 must be dropped
    logic [15:0] exp_q[$]; // expected words, oldest first
    // released line shows the inverse of its last level
    assign sdo_line = (sdo_oe === 1'b1) ? sdo : ~last_sdo;
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    spi_frame_and_fault_latch #(.N(NC), .SHORT_DLY_CYC(SHORT), .LONG_DLY_CYC(LONG),
        .REARM_DLY_CYC(REARM)) u_dut (
        .mclk, .sys_rst, .sclk_pin, .cs_n_pin, .sdi_pin, .sdo, .sdo_oe, .tx_word,
        .rx_word, .rx_valid, .rx_ready, .frame_overrun, .channel_cmd, .over_high_pin,
        .over_low_pin, .over_temp_pin, .rev_detect_pin, .rev_over_pin, .rev_zero_pin,
        .diag_busy, .diagnosis_clear_command, .reverse_comparator_enable, .gate_on,
        .diag_code, .fault_latched, .rev_on);
    spi_host_model u_host (.mclk, .sdo_line, .sclk_pin, .cs_n_pin, .sdi_pin);
    // ----------
    // checking and closing
    // ----------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // random receiver stalls; watcher pops the oldest note per word
    always @(posedge mclk) begin
        rx_ready <= !stall && ($random(seed) % 4 != 0);
        if (sdo_oe === 1'b1) last_sdo <= sdo;
        if (frame_overrun === 1'b1) ovr_cnt++;
        if (!sys_rst && rx_valid === 1'b1 && rx_ready === 1'b1) begin
            if (exp_q.size() == 0) check(32'h1, 32'h0, "unexpected word");
            else check(rx_word, exp_q.pop_front(), "rx_word");
        end
    end
    // hang guard, well above the expected run
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            summarize();
        end
    end
    // ----------
    // stimulus tasks
    // ----------
    // one burst; the note is queued only for an accepted count
    task automatic frame(input int nb, input bit lost);
        logic [31:0] d, got;
        logic [15:0] tx;
        logic [63:0] s;
        logic [47:0] st;
        d = $random(seed);
        tx = $random(seed);
        @(posedge mclk);
        tx_word <= tx;
        s = ({48'h0, tx} << nb) | ({32'h0, d} & ((64'h1 << nb) - 64'h1));
        st = {tx, d << (32 - nb)};
        if (nb % 8 == 0 && !lost) exp_q.push_back(s[15:0]);
        u_host.xfer(nb, d, got);
        check(got, st >> (48 - nb), "sdo bits");
    endtask
    // overload or temperature trip on channel c, then latch, code, deferral and clear
    task automatic trip(input int c, input int kind, input int lim, input bit busy);
        int n;
        n = 0;
        channel_cmd[c] <= 1'b1;
        diag_busy <= busy;
        repeat (4) @(posedge mclk);
        check(gate_on[c], 1'b1, "gate on");
        case (kind)
            0: over_high_pin[c] <= 1'b1;
            1: over_low_pin[c] <= 1'b1;
            default: over_temp_pin[c] <= 1'b1;
        endcase
        while (gate_on[c] === 1'b1 && n < 300) begin
            @(posedge mclk);
            n++;
        end
        check(n >= lim && n <= lim + 8, 1'b1, "trip delay");
        over_high_pin <= '0;
        over_low_pin <= '0;
        over_temp_pin <= '0;
        repeat (4) @(posedge mclk);
        check({fault_latched[c], gate_on[c]}, 2'h2, "latched off");
        check(diag_code[2*c+:2], busy ? 2'h0 : 2'h2, "held code");
        diag_busy <= 1'b0;
        repeat (3) @(posedge mclk);
        check(diag_code[2*c+:2], 2'h2, "code");
        diagnosis_clear_command[c] <= 1'b1;
        @(posedge mclk);
        diagnosis_clear_command[c] <= 1'b0;
        repeat (3) @(posedge mclk);
        check({fault_latched[c], gate_on[c], diag_code[2*c+:2]}, 4'h4, "cleared");
        channel_cmd[c] <= 1'b0;
        @(posedge mclk);
    endtask
    // ----------
    // main sequence
    // ----------
    initial begin
        int c, n;
        sys_rst = 1'b1;
        {rx_ready, diag_busy, reverse_comparator_enable, stall, last_sdo} = '0;
        tx_word = 16'h0000;
        {channel_cmd, over_high_pin, over_low_pin, over_temp_pin} = '0;
        {rev_detect_pin, rev_over_pin, rev_zero_pin, diagnosis_clear_command} = '0;
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge mclk);
        foreach (nbs[i]) frame(nbs[i], 1'b0);
        // receiver stalls: two words held, the third refused
        repeat (40) @(posedge mclk);
        stall <= 1'b1;
        repeat (2) frame(16, 1'b0);
        frame(16, 1'b1);
        repeat (4) @(posedge mclk);
        check(ovr_cnt, 1, "overrun");
        stall <= 1'b0;
        n = 0;
        while (exp_q.size() != 0 && n < 100) begin
            @(posedge mclk);
            n++;
        end
        repeat (3) @(posedge mclk);
        check({exp_q.size(), rx_valid}, 1'b0, "drained");
        // channel protection: high, low on a random channel, deferred temp
        c = {$random(seed)} % NC;
        trip(0, 0, SHORT, 1'b0);
        trip(c, 1, LONG, 1'b0);
        trip(0, 2, 0, 1'b1);
        // reverse comparator: disabled, active, trip, wait for zero, rearm
        rev_detect_pin[0] <= 1'b1;
        repeat (6) @(posedge mclk);
        check({rev_on[0], gate_on[0]}, 2'h0, "rev disabled");
        reverse_comparator_enable <= 1'b1;
        repeat (6) @(posedge mclk);
        check({rev_on[0], gate_on[0]}, 2'h3, "rev active");
        rev_over_pin[0] <= 1'b1;
        repeat (6) @(posedge mclk);
        rev_over_pin[0] <= 1'b0;
        repeat (40) @(posedge mclk);
        check({rev_on[0], gate_on[0]}, 2'h0, "rev wait zero");
        rev_zero_pin[0] <= 1'b1;
        n = 0;
        while (rev_on[0] !== 1'b1 && n < 200) begin
            @(posedge mclk);
            n++;
        end
        check(n >= REARM && n <= REARM + 8, 1'b1, "rearm delay");
        rev_detect_pin <= '0;
        rev_zero_pin <= '0;
        reverse_comparator_enable <= 1'b0;
        repeat (6) @(posedge mclk);
        summarize();
    end
endmodule
